/* File: design/sickc_pkg.sv */
package sickc_pkg;

    localparam logic [7:0] SICKC_CTRL_ADDR      = 8'h0d;
    localparam logic [7:0] SICKC_CTRL_RESET     = 8'h34;

    localparam int         SICKC_LOSS_CNT_LSB   = 5;
    localparam int         SICKC_ALL_TRIALS_BIT = 3;
    localparam int         SICKC_KILL_SEL_LSB   = 0;

    localparam int         SICKC_TABLE_DEPTH    = 8;
    localparam int         SICKC_STD_W          = 3;
    localparam int         SICKC_NUM_STD        = 8;

    localparam logic [3:0] SICKC_LOSS_FIELDS_00 = 4'h1;
    localparam logic [3:0] SICKC_LOSS_FIELDS_01 = 4'h3;
    localparam logic [3:0] SICKC_LOSS_FIELDS_10 = 4'h7;
    localparam logic [3:0] SICKC_LOSS_FIELDS_11 = 4'hf;

    localparam int         SICKC_BURST_THR_LSB  = 0;
    localparam int         SICKC_BURST_HYS_LSB  = 5;

    typedef enum logic [1:0] {
        SICKC_KILL_AUTO  = 2'h0,
        SICKC_KILL_NEVER = 2'h1,
        SICKC_KILL_ALWAYS= 2'h2,
        SICKC_KILL_BURST = 2'h3
    } sickc_kill_t;

    typedef enum logic [2:0] {
        SICKC_ST_SEARCH = 3'b001,
        SICKC_ST_DECIDE = 3'b010,
        SICKC_ST_TRACK  = 3'b100
    } sickc_state_t;

endpackage

/* File: design/sickc_loss_counter.sv */
`timescale 1ns/1ps
module sickc_loss_counter
    import sickc_pkg::*;
(
    input  wire logic       clk,
    input  wire logic       srst,
    input  wire logic       ce,
    input  wire logic       tracking,
    input  wire logic       field_strobe,
    input  wire logic       criteria_ok,
    input  wire logic [3:0] limit,
    output logic            lost_r
);

    logic [3:0] fail_cnt_r;

    // Counts successive failing fields; any good field restarts the run
    always_ff @(posedge clk)
    begin
        if (srst)
        begin
            fail_cnt_r <= 4'h0;
            lost_r     <= 1'b0;
        end
        else if (ce)
        begin
            lost_r <= 1'b0;
            if (!tracking)
            begin
                fail_cnt_r <= 4'h0;
            end
            else if (field_strobe)
            begin
                if (criteria_ok)
                begin
                    fail_cnt_r <= 4'h0;
                end
                else if (fail_cnt_r + 4'h1 >= limit)
                begin
                    fail_cnt_r <= 4'h0;
                    lost_r     <= 1'b1;
                end
                else
                begin
                    fail_cnt_r <= fail_cnt_r + 4'h1;
                end
            end
        end
    end

endmodule // sickc_loss_counter

/* File: design/sickc_ctrl.sv */
// Function
// - loss_field_count 00/01/10/11 selects 1/3/7/15 failing fields for loss.
// - While tracking, selected successive failing fields declare the standard lost.
// - Identification table holds eight entries; a standard may repeat.
// - Table entries 0 to tbl_last are each tried once before any decision.
// - With all_trials_required set, every trial of a standard must pass.
// - With all_trials_required clear, one passing trial identifies the standard.
// - color_kill_select: auto, never killed, always killed, auto with burst control.
// - Automatic mode kills colour until a standard is identified.
// - Burst mode kills below threshold, restores above threshold plus hysteresis.
`timescale 1ns/1ps
module sickc_ctrl
    import sickc_pkg::*;
(
    input  wire logic                   clk,
    input  wire logic                   srst,
    input  wire logic                   ce,
    input  wire logic                   reg_wr,
    input  wire logic                   reg_rd,
    input  wire logic [7:0]             reg_addr,
    input  wire logic [7:0]             reg_wdata,
    output logic      [7:0]             reg_rdata_r,
    input  wire logic                   tbl_wr,
    input  wire logic [2:0]             tbl_index,
    input  wire logic [SICKC_STD_W-1:0] tbl_std,
    input  wire logic [2:0]             tbl_last,
    input  wire logic                   trial_done,
    input  wire logic                   trial_ok,
    input  wire logic                   field_strobe,
    input  wire logic                   criteria_ok,
    input  wire logic                   burst_valid,
    input  wire logic [4:0]             burst_amp,
    input  wire logic [7:0]             burst_kill_level,
    output logic      [2:0]             trial_entry_r,
    output logic      [SICKC_STD_W-1:0] trial_std_r,
    output logic                        std_identified_r,
    output logic      [SICKC_STD_W-1:0] ident_std_r,
    output logic                        std_lost_r,
    output logic                        color_kill_r
);

    logic [7:0]             ctrl_r;
    logic [SICKC_STD_W-1:0] tbl_mem [SICKC_TABLE_DEPTH];
    sickc_state_t           state_r;
    logic [SICKC_NUM_STD-1:0] seen_r;
    logic [SICKC_NUM_STD-1:0] any_ok_r;
    logic [SICKC_NUM_STD-1:0] all_ok_r;
    logic [SICKC_NUM_STD-1:0] decided;
    logic                   found;
    logic [SICKC_STD_W-1:0] found_std;
    logic [3:0]             loss_limit;
    logic                   all_req;
    sickc_kill_t            kill_sel;
    logic                   burst_kill_r;
    logic                   lost;
    logic                   clear_acc;
    logic [5:0]             restore_lvl;

    assign all_req  = ctrl_r[SICKC_ALL_TRIALS_BIT];
    assign kill_sel = sickc_kill_t'(ctrl_r[SICKC_KILL_SEL_LSB +: 2]);

    // All bits are stored as written; reserved-bit values are software's duty
    always_ff @(posedge clk)
    begin
        if (srst)
        begin
            ctrl_r <= SICKC_CTRL_RESET;
        end
        else if (ce && reg_wr && reg_addr == SICKC_CTRL_ADDR)
        begin
            ctrl_r <= reg_wdata;
        end
    end

    always_ff @(posedge clk)
    begin
        if (srst)
        begin
            reg_rdata_r <= 8'h00;
        end
        else if (ce && reg_rd)
        begin
            reg_rdata_r <= (reg_addr == SICKC_CTRL_ADDR) ? ctrl_r : 8'h00;
        end
    end

    // Table has no reset; entries are loaded by software before use
    always_ff @(posedge clk)
    begin
        if (ce && tbl_wr)
        begin
            tbl_mem[tbl_index] <= tbl_std;
        end
    end

    always_comb
    begin
        case (ctrl_r[SICKC_LOSS_CNT_LSB +: 2])
            2'h0:    loss_limit = SICKC_LOSS_FIELDS_00;
            2'h1:    loss_limit = SICKC_LOSS_FIELDS_01;
            2'h2:    loss_limit = SICKC_LOSS_FIELDS_10;
            default: loss_limit = SICKC_LOSS_FIELDS_11;
        endcase
    end

    assign clear_acc = (state_r == SICKC_ST_DECIDE) ||
                       (state_r == SICKC_ST_TRACK && lost);

    // Per-standard trial bookkeeping over one full table pass
    genvar s;
    generate
        for (s = 0; s < SICKC_NUM_STD; s++)
        begin : g_std
            logic hit;
            assign hit = (state_r == SICKC_ST_SEARCH) && trial_done &&
                         (trial_std_r == SICKC_STD_W'(s));
            always_ff @(posedge clk)
            begin
                if (srst)
                begin
                    seen_r[s]   <= 1'b0;
                    any_ok_r[s] <= 1'b0;
                    all_ok_r[s] <= 1'b1;
                end
                else if (ce)
                begin
                    if (clear_acc)
                    begin
                        seen_r[s]   <= 1'b0;
                        any_ok_r[s] <= 1'b0;
                        all_ok_r[s] <= 1'b1;
                    end
                    else if (hit)
                    begin
                        seen_r[s]   <= 1'b1;
                        any_ok_r[s] <= any_ok_r[s] | trial_ok;
                        all_ok_r[s] <= all_ok_r[s] & trial_ok;
                    end
                end
            end
            assign decided[s] = seen_r[s] & (all_req ? all_ok_r[s] : any_ok_r[s]);
        end
    endgenerate

    // Lowest standard code wins when several pass in one pass of the table
    always_comb
    begin
        found     = 1'b0;
        found_std = '0;
        for (int i = SICKC_NUM_STD - 1; i >= 0; i--)
        begin
            if (decided[i])
            begin
                found     = 1'b1;
                found_std = SICKC_STD_W'(i);
            end
        end
    end

    always_ff @(posedge clk)
    begin
        if (srst)
        begin
            state_r          <= SICKC_ST_SEARCH;
            trial_entry_r    <= 3'h0;
            std_identified_r <= 1'b0;
            ident_std_r      <= '0;
        end
        else if (ce)
        begin
            case (state_r)
                SICKC_ST_SEARCH:
                begin
                    if (trial_done)
                    begin
                        if (trial_entry_r == tbl_last)
                        begin
                            state_r       <= SICKC_ST_DECIDE;
                            trial_entry_r <= 3'h0;
                        end
                        else
                        begin
                            trial_entry_r <= trial_entry_r + 3'h1;
                        end
                    end
                end
                SICKC_ST_DECIDE:
                begin
                    if (found)
                    begin
                        state_r          <= SICKC_ST_TRACK;
                        std_identified_r <= 1'b1;
                        ident_std_r      <= found_std;
                    end
                    else
                    begin
                        state_r <= SICKC_ST_SEARCH;
                    end
                end
                SICKC_ST_TRACK:
                begin
                    if (lost)
                    begin
                        state_r          <= SICKC_ST_SEARCH;
                        std_identified_r <= 1'b0;
                    end
                end
                default:
                begin
                    state_r          <= SICKC_ST_SEARCH;
                    trial_entry_r    <= 3'h0;
                    std_identified_r <= 1'b0;
                end
            endcase
        end
    end

    // Registered so the standard on trial tracks the entry pointer
    always_ff @(posedge clk)
    begin
        if (srst)
        begin
            trial_std_r <= '0;
        end
        else if (ce)
        begin
            trial_std_r <= tbl_mem[(state_r == SICKC_ST_SEARCH && trial_done &&
                                    trial_entry_r != tbl_last) ?
                                   trial_entry_r + 3'h1 :
                                   (state_r == SICKC_ST_SEARCH ? trial_entry_r : 3'h0)];
        end
    end

    sickc_loss_counter u_loss (
        .clk          (clk),
        .srst         (srst),
        .ce           (ce),
        .tracking     (state_r == SICKC_ST_TRACK),
        .field_strobe (field_strobe),
        .criteria_ok  (criteria_ok),
        .limit        (loss_limit),
        .lost_r       (lost)
    );

    assign std_lost_r = lost;

    assign restore_lvl = {1'b0, burst_kill_level[SICKC_BURST_THR_LSB +: 5]} +
                         {3'h0, burst_kill_level[SICKC_BURST_HYS_LSB +: 3]};

    // Hysteresis keeps a marginal burst from toggling colour every line
    always_ff @(posedge clk)
    begin
        if (srst)
        begin
            burst_kill_r <= 1'b1;
        end
        else if (ce && burst_valid)
        begin
            if (burst_amp < burst_kill_level[SICKC_BURST_THR_LSB +: 5])
            begin
                burst_kill_r <= 1'b1;
            end
            else if (burst_kill_r && {1'b0, burst_amp} > restore_lvl)
            begin
                burst_kill_r <= 1'b0;
            end
        end
    end

    always_ff @(posedge clk)
    begin
        if (srst)
        begin
            color_kill_r <= 1'b1;
        end
        else if (ce)
        begin
            case (kill_sel)
                SICKC_KILL_AUTO:   color_kill_r <= ~std_identified_r;
                SICKC_KILL_NEVER:  color_kill_r <= 1'b0;
                SICKC_KILL_ALWAYS: color_kill_r <= 1'b1;
                SICKC_KILL_BURST:  color_kill_r <= ~std_identified_r | burst_kill_r;
                default:           color_kill_r <= 1'b1;
            endcase
        end
    end

endmodule // sickc_ctrl

/* File: sim/sickc_ctrl_asserts.sv */
`timescale 1ns/1ps
module sickc_ctrl_asserts
    import sickc_pkg::*;
(
    input wire logic       clk,
    input wire logic       srst,
    input wire logic       ce,
    input wire logic       reg_wr,
    input wire logic       reg_rd,
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic [7:0] reg_rdata_r,
    input wire logic       trial_done,
    input wire logic [2:0] tbl_last,
    input wire logic [2:0] trial_entry_r,
    input wire logic       field_strobe,
    input wire logic       criteria_ok,
    input wire logic       std_identified_r,
    input wire logic       std_lost_r,
    input wire logic       color_kill_r
);
    logic [7:0] ctrl_m;
    logic [7:0] rd_exp;
    // Mirror of the control register, rebuilt from the write port
    always_ff @(posedge clk)
        if (srst) ctrl_m <= SICKC_CTRL_RESET;
        else if (ce && reg_wr && reg_addr == SICKC_CTRL_ADDR) ctrl_m <= reg_wdata;
    always_ff @(posedge clk)
        if (srst) rd_exp <= 8'h00;
        else if (ce && reg_rd) rd_exp <= (reg_addr == SICKC_CTRL_ADDR) ? ctrl_m : 8'h00;
    default clocking cb @(posedge clk); endclocking
    default disable iff (srst);
    sequence s_fail;
        ce && field_strobe && !criteria_ok && std_identified_r && !std_lost_r;
    endsequence
    sequence s_lost;
        std_lost_r ##1 !std_identified_r;
    endsequence
    a_rst_state: assert property (disable iff (1'b0) srst && ce |=> color_kill_r
        && !std_identified_r && !std_lost_r) else $error("reset state wrong");
    a_rd_data: assert property (ce && reg_rd |=> reg_rdata_r == rd_exp)
        else $error("read data wrong");
    a_loss_one: assert property (s_fail ##0 ctrl_m[6:5] == 2'h0 |=> s_lost)
        else $error("single failing field did not declare loss");
    a_lost_pulse: assert property (std_lost_r |-> $past(std_identified_r) ##1 !std_lost_r)
        else $error("loss pulse wrong");
    a_ident_hold: assert property (std_identified_r && !std_lost_r |=> std_identified_r)
        else $error("identification dropped without loss");
    a_all_tried: assert property ($rose(std_identified_r) |-> $past(trial_done, 2)
        && $past(trial_entry_r, 2) == $past(tbl_last, 2)) else $error("decided early");
    a_kill_never: assert property (ce && ctrl_m[1:0] == 2'h1 |=> !color_kill_r)
        else $error("colour killed in never mode");
    a_kill_always: assert property (ce && ctrl_m[1:0] == 2'h2 |=> color_kill_r)
        else $error("colour kept in always mode");
    a_kill_auto: assert property (ce && ctrl_m[1:0] == 2'h0 |=>
        color_kill_r == !$past(std_identified_r)) else $error("auto kill wrong");
endmodule // sickc_ctrl_asserts

bind sickc_ctrl sickc_ctrl_asserts u_asserts (.clk(clk), .srst(srst), .ce(ce),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_rdata_r(reg_rdata_r), .trial_done(trial_done), .tbl_last(tbl_last),
    .trial_entry_r(trial_entry_r), .field_strobe(field_strobe),
    .criteria_ok(criteria_ok), .std_identified_r(std_identified_r),
    .std_lost_r(std_lost_r), .color_kill_r(color_kill_r));

/* File: sim/tb.sv */
`timescale 1ns/1ps
module tb
    import sickc_pkg::*;
;
    logic       clk = 0, srst = 1, ce = 1, reg_wr = 0, reg_rd = 0, tbl_wr = 0;
    logic       trial_done = 0, trial_ok = 0, field_strobe = 0, criteria_ok = 0;
    logic       burst_valid = 0, std_identified_r, std_lost_r, color_kill_r, flag;
    logic [7:0] reg_addr = 0, reg_wdata = 0, burst_kill_level = 0, reg_rdata_r, ctrl_m;
    logic [2:0] tbl_index = 0, tbl_std = 0, tbl_last = 0;
    logic [2:0] trial_entry_r, trial_std_r, ident_std_r;
    logic [4:0] burst_amp = 0;
    logic [31:0] seed = 32'h0000_2b70;
    int         n_mismatch = 0, n_checks = 0, fcnt, nlim, thr, hys;

    sickc_ctrl dut (.clk(clk), .srst(srst), .ce(ce), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata_r(reg_rdata_r),
        .tbl_wr(tbl_wr), .tbl_index(tbl_index), .tbl_std(tbl_std), .tbl_last(tbl_last),
        .trial_done(trial_done), .trial_ok(trial_ok), .field_strobe(field_strobe),
        .criteria_ok(criteria_ok), .burst_valid(burst_valid), .burst_amp(burst_amp),
        .burst_kill_level(burst_kill_level), .trial_entry_r(trial_entry_r),
        .trial_std_r(trial_std_r), .std_identified_r(std_identified_r),
        .ident_std_r(ident_std_r), .std_lost_r(std_lost_r), .color_kill_r(color_kill_r));

    always #2 clk = ~clk;

    function automatic logic [31:0] xs(input logic [31:0] x);
        x ^= x << 13;
        x ^= x >> 17;
        x ^= x << 5;
        return x;
    endfunction
    function automatic logic km(input logic [1:0] m, input logic id, input logic f);
        return m == 2'h0 ? !id : m == 2'h1 ? 1'b0 : m == 2'h2 ? 1'b1 : (!id | f);
    endfunction
    task automatic conclude;
        $display("Checks %0d, mismatches %0d", n_checks, n_mismatch);
        if (n_mismatch == 0 && n_checks > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask
    task automatic ck(input logic [7:0] got, input logic [7:0] exp);
        n_checks++;
        if (got !== exp)
        begin
            n_mismatch++;
            $display("Error at %0t: saw %h expected %h", $time, got, exp);
        end
    endtask
    // Reset also rebuilds the model; the table itself survives reset
    task automatic rst;
        srst <= 1;
        repeat (6) @(posedge clk);
        srst <= 0;
        ctrl_m = SICKC_CTRL_RESET;
        flag = 1;
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1;
        @(posedge clk);
        reg_wr <= 0;
        if (a == 8'h0d && ce) ctrl_m = d;
        // One idle edge keeps back-to-back writes from retouching the strobe
        @(posedge clk);
    endtask
    task automatic rd(input logic [7:0] a);
        reg_addr <= a;
        reg_rd <= 1;
        @(posedge clk);
        reg_rd <= 0;
        #1 ck(reg_rdata_r, a == 8'h0d ? ctrl_m : 8'h00);
        @(posedge clk);
    endtask
    // A spare cycle after each trial lets the entry pointer settle
    task automatic trial(input logic ok);
        trial_ok <= ok;
        trial_done <= 1;
        @(posedge clk);
        trial_done <= 0;
        @(posedge clk);
    endtask
    task automatic pass(input logic a, input logic b, input logic exp);
        trial(a);
        trial(b);
        repeat (3) @(posedge clk);
        #1 ck(std_identified_r, exp);
        ck(trial_std_r, 8'h02);
        if (exp) ck(ident_std_r, 8'h02);
        else ck(trial_entry_r, 8'h00);
        @(posedge clk);
    endtask
    task automatic field(input logic ok);
        field_strobe <= 1;
        criteria_ok <= ok;
        @(posedge clk);
        field_strobe <= 0;
        fcnt = ok ? 0 : fcnt + 1;
        #1 ck(std_lost_r, fcnt == nlim);
        @(posedge clk);
    endtask
    task automatic kchk(input logic id);
        @(posedge clk);
        #1 ck(color_kill_r, km(ctrl_m[1:0], id, flag));
        @(posedge clk);
    endtask

    initial
    begin
        rst;
        rd(8'h0d);
        rd(8'h0e);
        for (int i = 0; i < 4; i++)
        begin
            seed = xs(seed);
            wr(8'h0d, (seed[7:0] & 8'h6b) | 8'h14);
            wr(8'h0e, seed[15:8]);
            rd(8'h0d);
        end
        // Clock enable low must freeze the register against a write
        ce <= 0;
        wr(8'h0d, (~ctrl_m & 8'h6b) | 8'h14);
        ce <= 1;
        rd(8'h0d);
        tbl_last <= 3'h1;
        for (int i = 0; i < 8; i++)
        begin
            tbl_index <= i[2:0];
            tbl_std <= i < 2 ? 3'h2 : 3'h5;
            tbl_wr <= 1;
            @(posedge clk);
        end
        tbl_wr <= 0;
        for (int all = 0; all < 2; all++)
            for (int p = 0; p < 3; p++)
            begin
                rst;
                wr(8'h0d, 8'h15 | (all[7:0] << 3));
                pass(p > 0, p > 1, all ? p > 1 : p > 0);
            end
        for (int lc = 0; lc < 4; lc++)
        begin
            rst;
            wr(8'h0d, 8'h15 | (lc[7:0] << 5));
            nlim = (2 << lc) - 1;
            pass(1, 1, 1);
            fcnt = 0;
            repeat (nlim - 1) field(0);
            field(1);
            repeat (nlim) field(0);
            #1 ck(std_identified_r, 8'h00);
            @(posedge clk);
        end
        rst;
        for (int id = 0; id < 2; id++)
        begin
            if (id) pass(1, 1, 1);
            for (int m = 0; m < 4; m++)
            begin
                wr(8'h0d, 8'h34 | m[7:0]);
                kchk(id[0]);
            end
        end
        seed = xs(seed);
        burst_kill_level <= {seed[7:5], 2'b01, seed[2:0]};
        thr = {2'b01, seed[2:0]};
        hys = seed[7:5];
        @(posedge clk);
        repeat (24)
        begin
            seed = xs(seed);
            burst_amp <= seed[4:0];
            burst_valid <= 1;
            @(posedge clk);
            burst_valid <= 0;
            if (seed[4:0] < thr) flag = 1;
            else if (flag && seed[4:0] > thr + hys) flag = 0;
            kchk(1);
        end
        conclude;
    end

    initial
    begin
        #100000;
        n_mismatch++;
        conclude;
    end
endmodule // tb
